//--- hdl/tsp_map.vh
// Constants for the table search and pointer unit.
// Assumes a 16-bit word memory with read data valid in the same cycle that rd_en is high.
`ifndef TSP_MAP_VH
`define TSP_MAP_VH
`define TSP_OP_FIND   2'h1
`define TSP_OP_GREATER 2'h2
`define TSP_OP_MOVE   2'h3
`define TSP_LEN_MAX   8'hff
`define TSP_PTR_WRAP  16'h0001
`define TSP_ZERO16    16'h0000
`endif

//--- hdl/tsp_unit.v
// Word-table search and pointer-move engine for a controller CPU.
// Assumes a memory with read data valid in the same cycle that rd_en is high, writes in one cycle.
//
// Function
// - Equal search covers tables of 0 to 255 words
// - Length stack2, start stack1, offset accumulator
// - Offset taken from accumulator low sixteen bits
// - Match returns offset from table start
// - Offset outside table or no match fails
// - Key is memory word or 16-bit constant
// - Greater search: first word above key
// - Greater search always starts at first word
// - No greater word: zero and fail flag
// - Fail flag holds until next flag writer
// - Move copies word then increments pointer
// - Table first word is the pointer
// - Move: length stack1, start accumulator, destination given
// - Pointer at length wraps to one
// - Pointer zero or length selects first data word
// - Move runs once per start; repeated starts repeat it
// - Table-end flag when new pointer equals length
// - Status flags cleared at scan end, unless a search or move sets one in that cycle
// - Every memory location is sixteen bits
`include "tsp_map.vh"
`timescale 1ns/1ps
`default_nettype none
module tsp_unit (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  input wire clk_en,
  // Command from sequencer
  input wire start,
  input wire [1:0] op,
  input wire [15:0] stack1,
  input wire [15:0] stack2,
  input wire [31:0] acc_in,
  input wire [15:0] key_const,
  input wire key_is_mem,
  input wire [15:0] key_addr,
  input wire [15:0] dest_addr,
  input wire scan_end,
  // Memory port
  output reg mem_rd_en,
  output reg mem_wr_en,
  output reg [15:0] mem_addr,
  output reg [15:0] mem_wdata,
  input wire [15:0] mem_rdata,
  // Results
  output reg busy,
  output reg done,
  output reg [31:0] acc_out,
  output reg acc_we,
  output reg search_fail_flag,
  output reg table_end_flag
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_KEY = 3'h1;
  localparam ST_SCAN = 3'h2;
  localparam ST_PTR = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_WRITE = 3'h5;
  localparam ST_WAIT = 3'h6;

  reg rs1_reg;
  reg rs2_reg;
  reg [2:0] state_reg;
  reg [1:0] op_reg;
  reg [7:0] len_reg;
  reg [15:0] base_reg;
  reg [15:0] key_reg;
  reg [15:0] dest_reg;
  reg [7:0] idx_reg;
  reg [15:0] ptr_reg;
  wire rst_n = rs2_reg;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Greater compare is unsigned, words treated as 0..ffff
  function hit;
    input [1:0] f_op;
    input [15:0] f_word;
    input [15:0] f_key;
    begin
      if (f_op == `TSP_OP_FIND)
        hit = (f_word == f_key);
      else
        hit = (f_word > f_key);
    end
  endfunction

  // Word address of table entry n past the start
  function [15:0] entry;
    input [15:0] f_base;
    input [7:0] f_n;
    begin
      entry = f_base + {8'h00, f_n};
    end
  endfunction

  // Empty table, or offset at or past the length, fails before any table read
  function bad_start;
    input [1:0] f_op;
    input [7:0] f_len;
    input [15:0] f_off;
    begin
      if (f_len == 8'h00)
        bad_start = 1'b1;
      else if (f_op == `TSP_OP_FIND)
        bad_start = (f_off[15:8] != 8'h00) || (f_off[7:0] >= f_len);
      else
        bad_start = 1'b0;
    end
  endfunction

  // Nine-bit sum so index ff cannot wrap back into the table
  function last_word;
    input [7:0] f_idx;
    input [7:0] f_len;
    begin
      last_word = ({1'b0, f_idx} + 9'h001 >= {1'b0, f_len});
    end
  endfunction

  // Pointer zero and pointer equal to length both pick the first data word
  function [15:0] data_slot;
    input [15:0] f_base;
    input [15:0] f_ptr;
    input [7:0] f_len;
    begin
      if (f_ptr == `TSP_ZERO16 || f_ptr == {8'h00, f_len})
        data_slot = f_base + 16'h0001;
      else
        data_slot = f_base + f_ptr;
    end
  endfunction

  // Next pointer: wraps to one, never zero, once length is reached
  function [15:0] ptr_step;
    input [15:0] f_ptr;
    input [7:0] f_len;
    begin
      if (f_ptr == {8'h00, f_len})
        ptr_step = `TSP_PTR_WRAP;
      else
        ptr_step = f_ptr + 16'h0001;
    end
  endfunction

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rs1_reg <= 1'b0;
      rs2_reg <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rs2_reg <= rs1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Engine
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      op_reg <= 2'h0;
      len_reg <= 8'h00;
      base_reg <= 16'h0000;
      key_reg <= 16'h0000;
      dest_reg <= 16'h0000;
      idx_reg <= 8'h00;
      ptr_reg <= 16'h0000;
      mem_rd_en <= 1'b0;
      mem_wr_en <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
      acc_out <= 32'h00000000;
      acc_we <= 1'b0;
      search_fail_flag <= 1'b0;
      table_end_flag <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      acc_we <= 1'b0;
      mem_rd_en <= 1'b0;
      mem_wr_en <= 1'b0;
      if (scan_end) begin
        search_fail_flag <= 1'b0;
        table_end_flag <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (start && op != 2'h0) begin
            op_reg <= op;
            busy <= 1'b1;
            key_reg <= key_const;
            dest_reg <= dest_addr;
            if (op == `TSP_OP_FIND) begin
              len_reg <= stack2[7:0];
              base_reg <= stack1;
              idx_reg <= acc_in[7:0];
            end else begin
              len_reg <= stack1[7:0];
              base_reg <= acc_in[15:0];
              idx_reg <= 8'h00;
            end
            if (op == `TSP_OP_MOVE) begin
              mem_rd_en <= 1'b1;
              mem_addr <= acc_in[15:0];
              state_reg <= ST_PTR;
            end else if (key_is_mem) begin
              mem_rd_en <= 1'b1;
              mem_addr <= key_addr;
              state_reg <= ST_KEY;
            end else begin
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_KEY: begin
          key_reg <= mem_rdata;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (bad_start(op_reg, len_reg, acc_in[15:0])) begin
            search_fail_flag <= 1'b1;
            acc_out <= 32'h00000000;
            acc_we <= 1'b1;
            done <= 1'b1;
            busy <= 1'b0;
            state_reg <= ST_IDLE;
          end else begin
            mem_rd_en <= 1'b1;
            mem_addr <= entry(base_reg, idx_reg);
            state_reg <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          // One read in flight; the next is issued as this one is judged
          if (hit(op_reg, mem_rdata, key_reg)) begin
            acc_out <= {24'h000000, idx_reg};
            acc_we <= 1'b1;
            search_fail_flag <= 1'b0;
            done <= 1'b1;
            busy <= 1'b0;
            state_reg <= ST_IDLE;
          end else if (last_word(idx_reg, len_reg)) begin
            acc_out <= 32'h00000000;
            acc_we <= 1'b1;
            search_fail_flag <= 1'b1;
            done <= 1'b1;
            busy <= 1'b0;
            state_reg <= ST_IDLE;
          end else begin
            idx_reg <= idx_reg + 8'h01;
            mem_rd_en <= 1'b1;
            mem_addr <= entry(base_reg, idx_reg + 8'h01);
          end
        end
        ST_PTR: begin
          // Pointers past the length move nothing
          ptr_reg <= mem_rdata;
          if (mem_rdata > {8'h00, len_reg} || len_reg == 8'h00) begin
            done <= 1'b1;
            busy <= 1'b0;
            state_reg <= ST_IDLE;
          end else begin
            mem_rd_en <= 1'b1;
            mem_addr <= data_slot(base_reg, mem_rdata, len_reg);
            state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          mem_wr_en <= 1'b1;
          mem_addr <= dest_reg;
          mem_wdata <= mem_rdata;
          state_reg <= ST_WRITE;
        end
        ST_WRITE: begin
          mem_wr_en <= 1'b1;
          mem_addr <= base_reg;
          // Length one wraps onto itself, so the flag follows the new value
          mem_wdata <= ptr_step(ptr_reg, len_reg);
          table_end_flag <= (ptr_step(ptr_reg, len_reg) == {8'h00, len_reg});
          // One start per scan is the caller's job; repeated starts repeat the move
          done <= 1'b1;
          busy <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- verif/tsp_mem_model.sv
// Word memory model for the unit's memory port.
// Assumes reads answered within the rd_en cycle; the bench loads words directly.
`timescale 1ns/1ps
`default_nettype none
module tsp_mem_model (
  // Memory port
  input wire logic clk,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  output wire logic [15:0] rdata
);
  logic [15:0] m [0:1023];
  always @(posedge clk) begin
    if (wr_en) m[addr[9:0]] <= wdata;
  end
  // Unit samples rdata at the edge after rd_en; idle word inverted
  assign rdata = rd_en ? m[addr[9:0]] : ~m[addr[9:0]];
endmodule
`default_nettype wire

//--- verif/tsp_unit_sva.sv
// Checker for the table search and pointer unit.
// Assumes binding to the unit; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module tsp_unit_sva (
  // Clock, reset, inputs
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scan_end,
  input wire logic [15:0] stack1,
  input wire logic [15:0] mem_rdata,
  // Outputs
  input wire logic mem_wr_en,
  input wire logic [15:0] mem_wdata,
  input wire logic busy,
  input wire logic done,
  input wire logic [31:0] acc_out,
  input wire logic acc_we,
  input wire logic search_fail_flag,
  input wire logic table_end_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Handshake, move steps and status flags
  // ----------------------------------------
  sequence s_dest_wr; mem_wr_en && !done; endsequence
  sequence s_ptr_wr; mem_wr_en && done; endsequence
  a_done_pulse: assert property (done |=> !done) else $error("done too long");
  a_op_bound: assert property ($rose(busy) |-> ##[1:300] done) else $error("no done");
  a_move_pair: assert property (s_dest_wr |=> s_ptr_wr) else $error("no pointer write");
  a_ptr_wrap: assert property (s_ptr_wr |-> mem_wdata ==
    ($past(mem_rdata, 3) == stack1 ? 16'h0001 : $past(mem_rdata, 3) + 16'h0001)) else $error("bad pointer");
  a_tab_end: assert property (s_ptr_wr |-> table_end_flag == (mem_wdata == stack1))
    else $error("bad table end");
  a_scan_clear: assert property (scan_end |=> done || !(search_fail_flag || table_end_flag))
    else $error("flags kept");
  a_flag_hold: assert property (!$past(scan_end) && !done |-> $stable(search_fail_flag))
    else $error("flag moved");
  a_hit_flag: assert property (acc_we && acc_out != 0 |-> !search_fail_flag) else $error("hit failed");
endmodule
bind tsp_unit tsp_unit_sva u_sva (.clk, .arst_n, .scan_end, .stack1, .mem_rdata, .mem_wr_en, .mem_wdata,
  .busy, .done, .acc_out, .acc_we, .search_fail_flag, .table_end_flag);
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the table search and pointer unit.
// Assumes the memory model answers the memory port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, arst_n = 0, clk_en = 1, start = 0, key_is_mem = 0, scan_end = 0, srch = 0;
  logic [1:0] op = 2'h0;
  logic [15:0] stack1 = 16'h0, stack2 = 16'h0, key_const = 16'h0, p, kv, rv = 16'h0025;
  logic [15:0] key_addr = 16'h0040, dest_addr = 16'h0080;
  logic [31:0] acc_in = 32'h0;
  wire [15:0] mem_addr, mem_wdata, mem_rdata;
  wire [31:0] acc_out;
  wire mem_rd_en, mem_wr_en, busy, done, acc_we, search_fail_flag, table_end_flag;
  logic [32:0] exq [$];
  int err_total = 0, samples_checked = 0, cyc = 0, len, f, hit;
  always #5 clk = ~clk;
  tsp_unit DUT (.clk, .arst_n, .clk_en, .start, .op, .stack1, .stack2, .acc_in, .key_const, .key_is_mem,
    .key_addr, .dest_addr, .scan_end, .mem_rd_en, .mem_wr_en, .mem_addr, .mem_wdata, .mem_rdata, .busy,
    .done, .acc_out, .acc_we, .search_fail_flag, .table_end_flag);
  tsp_mem_model mem (.clk, .rd_en(mem_rd_en), .wr_en(mem_wr_en), .addr(mem_addr), .wdata(mem_wdata),
    .rdata(mem_rdata));
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One start pulse per operation
  task automatic go(input logic [1:0] o, input logic [15:0] s1, s2, input logic km, input logic [31:0] a);
    @(posedge clk);
    op <= o;
    stack1 <= s1;
    stack2 <= s2;
    acc_in <= a;
    key_const <= km ? ~kv : kv;
    key_is_mem <= km;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do @(posedge clk); while (done !== 1'b1);
    #1;
  endtask
  // ----------------------------------------
  // Result watcher and hang limit
  // ----------------------------------------
  always @(posedge clk) begin
    logic [32:0] e;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end else if (srch && done === 1'b1) begin
      e = exq.pop_front();
      chk("fail", e[32], search_fail_flag);
      if (e[31:0] != 32'hffffffff) chk("acc", e[31:0], acc_out);
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int t = 0; t < 30; t++) begin
      for (int i = 0; i < 16; i++) begin
        rv = nx(rv);
        mem.m[16 + i] = {12'h000, rv[3:0]};
      end
      rv = nx(rv);
      len = rv % 10;
      f = (t % 2) ? 0 : rv[7:4] % 11;
      kv = {12'h000, rv[11:8]};
      mem.m[64] = kv;
      hit = -1;
      for (int i = f; i < len; i++)
        if (hit < 0 && ((t % 2) ? mem.m[16 + i] > kv : mem.m[16 + i] == kv)) hit = i;
      exq.push_back((len != 0 && f >= len) ? {1'b1, 32'hffffffff} : (hit < 0) ? {1'b1, 32'h0} : {1'b0, 32'(hit)});
      srch = 1;
      go((t % 2) ? 2'h2 : 2'h1, (t % 2) ? 16'(len) : 16'h0010, 16'(len), t % 3 == 0, (t % 2) ? 32'h10 : f);
      srch = 0;
    end
    // Longest table, last offset, upper accumulator half ignored
    kv = 16'h0abc;
    mem.m[270] = kv;
    exq.push_back({1'b0, 32'h000000fe});
    srch = 1;
    go(2'h1, 16'h0010, 16'h00ff, 1'b0, 32'h123400fe);
    srch = 0;
    for (int i = 1; i < 7; i++) mem.m[256 + i] = 16'h0a00 + i;
    mem.m[256] = 16'h0000;
    for (int t = 0; t < 9; t++) begin
      if (t == 8) mem.m[256] = 16'h0007;
      p = mem.m[256];
      mem.m[128] = 16'hffff;
      go(2'h3, 16'h0006, 16'h0000, 1'b0, 32'h100);
      chk("dest", p > 6 ? 16'hffff : mem.m[256 + ((p == 0 || p == 6) ? 1 : p)], mem.m[128]);
      kv = p > 6 ? p : (p == 6 ? 16'h0001 : p + 1);
      chk("ptr", kv, mem.m[256]);
      if (p <= 6) chk("tend", kv == 6, table_end_flag);
      scan_end <= 1'b1;
      @(posedge clk);
      scan_end <= 1'b0;
      @(posedge clk);
      #1;
      chk("clr", 0, {search_fail_flag, table_end_flag});
    end
    end_of_test();
  end
endmodule
`default_nettype wire
